// [rtl/sscr_regs.svh]
// bit positions, select codes, default values and timing counts of the setup and calibration words
`ifndef SSCR_REGS_SVH
`define SSCR_REGS_SVH

// register select codes carried in the low nibble of every word
`define SSCR_SEL_HI            3
`define SSCR_SEL_LO            0
`define SSCR_SEL_SETUP         4'h0
`define SSCR_SEL_CAL           4'h1

// device setup word fields
`define SSCR_SU_TEST           30
`define SSCR_SU_TRIS           29
`define SSCR_SU_POL            28
`define SSCR_SU_BACKLASH_WIDTH_HI        27
`define SSCR_SU_BACKLASH_WIDTH_LO        26
`define SSCR_SU_REFERENCE_DIVIDER_VALUE_HI        25
`define SSCR_SU_REFERENCE_DIVIDER_VALUE_LO        12
`define SSCR_SU_PD             11
`define SSCR_SU_SRC            10
`define SSCR_SU_RATIO_HI       9
`define SSCR_SU_RATIO_LO       8
`define SSCR_SU_ICP_HI         7
`define SSCR_SU_ICP_LO         5
`define SSCR_SU_RESET          4

// output divide ratio codes
`define SSCR_RATIO_DIV1        2'h0
`define SSCR_RATIO_DIV2        2'h1
`define SSCR_RATIO_DIV4        2'h2

// calibration word fields
`define SSCR_CAL_START         31
`define SSCR_CAL_TARGET_FREQUENCY_MHZ_HI       30
`define SSCR_CAL_TARGET_FREQUENCY_MHZ_LO       18
`define SSCR_CAL_FRAC_HI       17
`define SSCR_CAL_FRAC_LO       11
`define SSCR_CAL_INT_HI        10
`define SSCR_CAL_INT_LO        4

// default values and the hundredths-per-MHz scale factor
`define SSCR_REFERENCE_DIVIDER_VALUE_DEFAULT      14'h0001
`define SSCR_HUNDREDTHS_PER_MHZ 14'h0064

// calibration run length in system clock cycles
`define SSCR_CAL_CYCLES        16'h03E8

// positions in the pin synchroniser vectors
`define SSCR_PIN_SCLK          0
`define SSCR_PIN_SDATA         1
`define SSCR_PIN_STROBE        2
`define SSCR_PIN_BUFEN         3
`define SSCR_PIN_RF            4

`endif

// [rtl/sscr_pkg.sv]
// types for the synthesizer setup and calibration register block
package sscr_pkg;

    // stored fields of the device setup word
    typedef struct packed {
        logic        pump_pulse_test;
        logic        pump_high_impedance;
        logic        detector_polarity;
        logic [1:0]  backlash_width;
        logic [13:0] reference_divider_value;
        logic        buffer_power_down_bit;
        logic        buffer_control_source;
        logic [1:0]  out_ratio;
        logic [2:0]  pump_current_select;
    } sscr_setup_t;

    // stored fields of the calibration word
    typedef struct packed {
        logic        start;
        logic [12:0] target_frequency_mhz;
        logic [6:0]  reference_hundredths;
        logic [6:0]  reference_mhz;
    } sscr_cal_t;

    // whole state of the block
    typedef struct packed {
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic [4:0]  prev;
        logic [31:0] shreg;
        sscr_setup_t setup;
        sscr_cal_t   cal;
        logic        cal_busy;
        logic [15:0] cal_count;
        logic [13:0] cal_ref_10khz;
        logic [12:0] cal_target_mhz;
        logic        rf_out;
        logic        div_phase;
        logic        up_obs;
        logic        down_obs;
        logic        pump_oe;
        logic        buffer_on;
    } sscr_state_t;

endpackage : sscr_pkg

// [rtl/sscr_top.sv]
// serial word capture and field decoding of the setup and calibration registers
//
// What this block does
// - synth output divided by one, two or four
// - ratio bits: 00 /1, 01 /2, 10 /4
// - setup bit 30 exposes detector up/down pulses
// - setup bit 29 floats the pump output
// - bits 27:26 pick the backlash pulse width
// - bit 28 picks detector polarity, 1 positive
// - reference divider from bits 25 to 12
// - pump current from bits 7 to 5
// - setup bit 4 returns registers to defaults
// - reference frequency kept in 10 kHz units
// - bits 10:4 hold whole reference MHz
// - bits 17:11 hold hundredths of a MHz
// - calibration runs on the programmed reference values
// - calibration bit 31 starts calibration
// - bit 31 self-clears when calibration ends
// - bits 30:18 hold target frequency in MHz
`include "sscr_regs.svh"

module sscr_top #(
    parameter logic [15:0] CAL_CYCLES = `SSCR_CAL_CYCLES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_serial_clk,
    input  wire logic        i_serial_data,
    input  wire logic        i_serial_strobe,
    input  wire logic        i_buffer_enable_pin,
    input  wire logic        i_rf_in,
    input  wire logic        i_pfd_up,
    input  wire logic        i_pfd_down,
    output logic             o_rf_out,
    output logic [1:0]       o_out_ratio,
    output logic             o_pump_up_obs,
    output logic             o_pump_down_obs,
    output logic             o_pump_oe,
    output logic             o_pump_high_impedance,
    output logic [1:0]       o_backlash_width,
    output logic             o_detector_polarity,
    output logic [13:0]      o_reference_divider_value,
    output logic [2:0]       o_pump_current_select,
    output logic             o_buffer_on,
    output logic [6:0]       o_reference_mhz,
    output logic [6:0]       o_reference_hundredths,
    output logic [12:0]      o_target_frequency_mhz,
    output logic             o_cal_start_bit,
    output logic             o_cal_busy,
    output logic [13:0]      o_cal_ref_10khz,
    output logic [12:0]      o_cal_target_mhz
);

    // defaults that a reset word or the reset input restore
    localparam sscr_pkg::sscr_setup_t SETUP_DEFAULT = '{
        pump_pulse_test:         1'b0,
        pump_high_impedance:     1'b0,
        detector_polarity:       1'b0,
        backlash_width:          2'h0,
        reference_divider_value: `SSCR_REFERENCE_DIVIDER_VALUE_DEFAULT,
        buffer_power_down_bit:   1'b0,
        buffer_control_source:   1'b0,
        out_ratio:               `SSCR_RATIO_DIV1,
        pump_current_select:     3'h0
    };
    localparam sscr_pkg::sscr_cal_t CAL_DEFAULT = '0;

    sscr_pkg::sscr_state_t st;
    sscr_pkg::sscr_state_t next_st;

    // every check below runs on the system clock and rests while reset is held
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic        sclk_rise;
    logic        strobe_rise;
    logic        rf_rise;
    logic [31:0] word;
    logic        setup_wr;
    logic        cal_wr;
    logic        cal_done;

    // reference frequency in 10 kHz steps from whole MHz and hundredths
    function automatic logic [13:0] sscr_ref_10khz(input logic [6:0] mhz, input logic [6:0] hund);
        logic [27:0] prod;
        prod = {7'h00, mhz} * {14'h0000, `SSCR_HUNDREDTHS_PER_MHZ};
        return prod[13:0] + {7'h00, hund};
    endfunction : sscr_ref_10khz

    // edge detection on the synchronised pins, word decode
    always_comb begin
        sclk_rise   = st.sync2[`SSCR_PIN_SCLK] & ~st.prev[`SSCR_PIN_SCLK];
        strobe_rise = st.sync2[`SSCR_PIN_STROBE] & ~st.prev[`SSCR_PIN_STROBE];
        rf_rise     = st.sync2[`SSCR_PIN_RF] & ~st.prev[`SSCR_PIN_RF];
        word        = st.shreg;
        setup_wr    = strobe_rise && (word[`SSCR_SEL_HI:`SSCR_SEL_LO] == `SSCR_SEL_SETUP);
        cal_wr      = strobe_rise && (word[`SSCR_SEL_HI:`SSCR_SEL_LO] == `SSCR_SEL_CAL);
        cal_done    = st.cal_busy && (st.cal_count == CAL_CYCLES - 16'h0001);
    end

    // next state of the whole block
    always_comb begin
        next_st = st;

        // two-flop synchronisers; prev holds the settled level of the cycle before
        next_st.sync1 = {i_rf_in, i_buffer_enable_pin, i_serial_strobe, i_serial_data, i_serial_clk};
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;

        // data shifts in first bit as most significant on each serial clock rise
        if (sclk_rise) begin
            next_st.shreg = {st.shreg[30:0], st.sync2[`SSCR_PIN_SDATA]};
        end

        // calibration run; completion clears the start bit
        if (st.cal_busy) begin
            if (cal_done) begin
                next_st.cal_busy  = 1'b0;
                next_st.cal.start = 1'b0;
                next_st.cal_count = 16'h0000;
            end else begin
                next_st.cal_count = st.cal_count + 16'h0001;
            end
        end

        // calibration word: fields load, a start bit launches a run
        if (cal_wr) begin
            next_st.cal.target_frequency_mhz = word[`SSCR_CAL_TARGET_FREQUENCY_MHZ_HI:`SSCR_CAL_TARGET_FREQUENCY_MHZ_LO];
            next_st.cal.reference_hundredths = word[`SSCR_CAL_FRAC_HI:`SSCR_CAL_FRAC_LO];
            next_st.cal.reference_mhz        = word[`SSCR_CAL_INT_HI:`SSCR_CAL_INT_LO];
            if (word[`SSCR_CAL_START]) begin
                // a new start beats a completion in the same cycle
                next_st.cal.start     = 1'b1;
                next_st.cal_busy      = 1'b1;
                next_st.cal_count     = 16'h0000;
                next_st.cal_ref_10khz = sscr_ref_10khz(word[`SSCR_CAL_INT_HI:`SSCR_CAL_INT_LO],
                                                       word[`SSCR_CAL_FRAC_HI:`SSCR_CAL_FRAC_LO]);
                next_st.cal_target_mhz = word[`SSCR_CAL_TARGET_FREQUENCY_MHZ_HI:`SSCR_CAL_TARGET_FREQUENCY_MHZ_LO];
            end
        end

        // setup word: either a register reset or a field load
        if (setup_wr) begin
            if (word[`SSCR_SU_RESET]) begin
                next_st.setup     = SETUP_DEFAULT;
                next_st.cal       = CAL_DEFAULT;
                next_st.cal_busy  = 1'b0;
                next_st.cal_count = 16'h0000;
            end else begin
                next_st.setup.pump_pulse_test         = word[`SSCR_SU_TEST];
                next_st.setup.pump_high_impedance     = word[`SSCR_SU_TRIS];
                next_st.setup.detector_polarity       = word[`SSCR_SU_POL];
                next_st.setup.backlash_width          = word[`SSCR_SU_BACKLASH_WIDTH_HI:`SSCR_SU_BACKLASH_WIDTH_LO];
                next_st.setup.reference_divider_value = word[`SSCR_SU_REFERENCE_DIVIDER_VALUE_HI:`SSCR_SU_REFERENCE_DIVIDER_VALUE_LO];
                next_st.setup.buffer_power_down_bit   = word[`SSCR_SU_PD];
                next_st.setup.buffer_control_source   = word[`SSCR_SU_SRC];
                next_st.setup.out_ratio               = word[`SSCR_SU_RATIO_HI:`SSCR_SU_RATIO_LO];
                next_st.setup.pump_current_select     = word[`SSCR_SU_ICP_HI:`SSCR_SU_ICP_LO];
            end
        end

        // pump drive enable and buffer state follow the new setup at once
        next_st.pump_oe   = ~next_st.setup.pump_high_impedance;
        next_st.buffer_on = next_st.setup.buffer_control_source ?
                            st.sync2[`SSCR_PIN_BUFEN] :
                            ~next_st.setup.buffer_power_down_bit;

        // detector pulses reach the observation outputs only in test mode
        next_st.up_obs   = i_pfd_up & st.setup.pump_pulse_test;
        next_st.down_obs = i_pfd_down & st.setup.pump_pulse_test;

        // output divider; code 11 is unused and behaves as divide by one
        case (st.setup.out_ratio)
            `SSCR_RATIO_DIV2: begin
                if (rf_rise) begin
                    next_st.rf_out = ~st.rf_out;
                end
            end
            `SSCR_RATIO_DIV4: begin
                if (rf_rise) begin
                    next_st.div_phase = ~st.div_phase;
                    if (st.div_phase) begin
                        next_st.rf_out = ~st.rf_out;
                    end
                end
            end
            default: begin
                next_st.rf_out    = st.sync2[`SSCR_PIN_RF];
                next_st.div_phase = 1'b0;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st           <= '0;
            st.setup     <= SETUP_DEFAULT;
            st.cal       <= CAL_DEFAULT;
            st.pump_oe   <= 1'b1;
            st.buffer_on <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_rf_out                  = st.rf_out;
    assign o_out_ratio               = st.setup.out_ratio;
    assign o_pump_up_obs             = st.up_obs;
    assign o_pump_down_obs           = st.down_obs;
    assign o_pump_oe                 = st.pump_oe;
    assign o_pump_high_impedance     = st.setup.pump_high_impedance;
    assign o_backlash_width          = st.setup.backlash_width;  // 00 1.5ns, 01 0.9ns, 10 3.8ns, 11 2.7ns
    assign o_detector_polarity       = st.setup.detector_polarity;
    assign o_reference_divider_value = st.setup.reference_divider_value;
    assign o_pump_current_select     = st.setup.pump_current_select;
    assign o_buffer_on               = st.buffer_on;
    assign o_reference_mhz           = st.cal.reference_mhz;
    assign o_reference_hundredths    = st.cal.reference_hundredths;
    assign o_target_frequency_mhz    = st.cal.target_frequency_mhz;
    assign o_cal_start_bit           = st.cal.start;
    assign o_cal_busy                = st.cal_busy;
    assign o_cal_ref_10khz           = st.cal_ref_10khz;
    assign o_cal_target_mhz          = st.cal_target_mhz;

    // checks on the decoded fields and the calibration sequence
    localparam int CAL_BOUND = 1000;

    a_div2_edges: assert property (
        ($past(st.setup.out_ratio) == `SSCR_RATIO_DIV2) && $changed(o_rf_out) |-> $past(rf_rise))
        else $error("divide-by-two output changed without an input edge");

    a_div1_follow: assert property (
        ($past(st.setup.out_ratio) == `SSCR_RATIO_DIV1) |-> (o_rf_out == $past(st.sync2[`SSCR_PIN_RF])))
        else $error("divide-by-one output does not follow the input");

    a_test_observe: assert property (
        !$past(st.setup.pump_pulse_test) |-> (!o_pump_up_obs && !o_pump_down_obs))
        else $error("detector pulses visible outside test mode");

    a_pump_drive: assert property (
        o_pump_oe == !o_pump_high_impedance)
        else $error("pump drive enable disagrees with the tristate bit");

    a_setup_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_reference_divider_value == $past(word[`SSCR_SU_REFERENCE_DIVIDER_VALUE_HI:`SSCR_SU_REFERENCE_DIVIDER_VALUE_LO])) &&
            (o_pump_current_select == $past(word[`SSCR_SU_ICP_HI:`SSCR_SU_ICP_LO])))
        else $error("setup fields not loaded from the word");

    a_reg_reset: assert property (
        setup_wr && word[`SSCR_SU_RESET] |=>
            (o_reference_divider_value == `SSCR_REFERENCE_DIVIDER_VALUE_DEFAULT) && !o_cal_start_bit && !o_cal_busy &&
            (o_target_frequency_mhz == 13'h0000))
        else $error("reset word did not restore defaults");

    a_buffer_select: assert property (
        !st.setup.buffer_control_source |-> (o_buffer_on == !st.setup.buffer_power_down_bit))
        else $error("buffer state does not follow the power-down bit");

    a_cal_launch: assert property (
        cal_wr && word[`SSCR_CAL_START] |=> o_cal_start_bit && o_cal_busy && (st.cal_count == 16'h0000))
        else $error("start bit did not launch calibration");

    a_cal_clears: assert property (
        $rose(o_cal_busy) |-> ##[1:CAL_BOUND] !o_cal_start_bit)
        else $error("start bit not cleared after calibration");

    a_cal_inputs: assert property (
        $rose(o_cal_busy) |->
            (o_cal_ref_10khz == {7'h00, o_reference_mhz} * `SSCR_HUNDREDTHS_PER_MHZ +
                                {7'h00, o_reference_hundredths}) &&
            (o_cal_target_mhz == o_target_frequency_mhz))
        else $error("calibration inputs differ from the programmed fields");

    a_select_ignore: assert property (
        strobe_rise && !setup_wr && !cal_wr |=> $stable(st.setup) && $stable(o_target_frequency_mhz))
        else $error("word with unknown select changed a register");

    // one check per stored field of a plain setup or calibration word, except the divider, power-down, source and start bits
    a_ratio_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_out_ratio == $past(word[`SSCR_SU_RATIO_HI:`SSCR_SU_RATIO_LO])))
        else $error("output ratio not loaded from the word");

    a_test_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (st.setup.pump_pulse_test == $past(word[`SSCR_SU_TEST])))
        else $error("pulse test bit not loaded from the word");

    a_tristate_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_pump_high_impedance == $past(word[`SSCR_SU_TRIS])))
        else $error("pump tristate bit not loaded from the word");

    a_backlash_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_backlash_width == $past(word[`SSCR_SU_BACKLASH_WIDTH_HI:`SSCR_SU_BACKLASH_WIDTH_LO])))
        else $error("backlash width not loaded from the word");

    a_polarity_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_detector_polarity == $past(word[`SSCR_SU_POL])))
        else $error("detector polarity not loaded from the word");

    a_current_load: assert property (
        setup_wr && !word[`SSCR_SU_RESET] |=>
            (o_pump_current_select == $past(word[`SSCR_SU_ICP_HI:`SSCR_SU_ICP_LO])))
        else $error("pump current not loaded from the word");

    a_buffer_pin: assert property (
        st.setup.buffer_control_source |-> (o_buffer_on == $past(st.sync2[`SSCR_PIN_BUFEN])))
        else $error("buffer state does not follow the enable pin");

    // divide by four toggles only on every second detected input rise
    a_div4_edges: assert property (
        ($past(st.setup.out_ratio) == `SSCR_RATIO_DIV4) && $changed(o_rf_out) |->
            $past(rf_rise) && $past(st.div_phase))
        else $error("divide-by-four output changed off its edge");

    a_ratio_unused: assert property (
        ($past(st.setup.out_ratio) == 2'h3) |-> (o_rf_out == $past(st.sync2[`SSCR_PIN_RF])))
        else $error("unused ratio code does not pass the input through");

    a_cal_mhz_load: assert property (
        cal_wr |=> (o_reference_mhz == $past(word[`SSCR_CAL_INT_HI:`SSCR_CAL_INT_LO])))
        else $error("reference whole MHz not loaded from the word");

    a_cal_hund_load: assert property (
        cal_wr |=> (o_reference_hundredths == $past(word[`SSCR_CAL_FRAC_HI:`SSCR_CAL_FRAC_LO])))
        else $error("reference hundredths not loaded from the word");

    a_cal_target_load: assert property (
        cal_wr |=> (o_target_frequency_mhz == $past(word[`SSCR_CAL_TARGET_FREQUENCY_MHZ_HI:`SSCR_CAL_TARGET_FREQUENCY_MHZ_LO])))
        else $error("target frequency not loaded from the word");

    // the stored start bit doubles as the completion indicator
    a_start_tracks: assert property (
        o_cal_start_bit == o_cal_busy)
        else $error("start bit and running state disagree");

    a_cal_length: assert property (
        $fell(o_cal_busy) && !$past(i_rst) && !($past(setup_wr) && $past(word[`SSCR_SU_RESET])) |->
            ($past(st.cal_count) == CAL_CYCLES - 16'h0001))
        else $error("calibration run length differs from the set count");

    c_cal_complete: cover property ($fell(o_cal_busy) && !o_cal_start_bit);
    c_div4_run:     cover property ((o_out_ratio == `SSCR_RATIO_DIV4) && $changed(o_rf_out));
    c_reset_word:   cover property (setup_wr && word[`SSCR_SU_RESET]);
    c_pin_buffer:   cover property (st.setup.buffer_control_source && $changed(o_buffer_on));
    c_cal_restart:  cover property (cal_wr && word[`SSCR_CAL_START] && st.cal_busy);

endmodule : sscr_top

// [dv/sscr_host_model.sv]
// host side of the three-wire link: shifts whole 32-bit words into the device
module sscr_host_model (
    output logic o_sclk,
    output logic o_sdata,
    output logic o_strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    // link idles with clock and strobe low
    initial begin
        o_sclk   = 1'b0;
        o_sdata  = 1'b0;
        o_strobe = 1'b0;
    end

    // msb first; the select nibble rides in the last four bits
    // strobe rises a full half period after the last clock fall, well clear of the last clock rise
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            o_sdata = w[i];
            #100 o_sclk = 1'b1;
            #100 o_sclk = 1'b0;
        end
        o_sdata = ~w[0]; // data is stale once the frame is shifted in
        #100 o_strobe = 1'b1;
        #100 o_strobe = 1'b0;
        #100;
    endtask : send_word
endmodule : sscr_host_model

// [dv/tb_top.sv]
// self-checking bench for the setup and calibration register block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] CAL_N = 16'h0008;

    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_buffer_enable_pin = 1'b0;
    logic        i_rf_in = 1'b0;
    logic        i_pfd_up = 1'b0;
    logic        i_pfd_down = 1'b0;
    logic        i_serial_clk, i_serial_data, i_serial_strobe;
    logic        o_rf_out, o_pump_up_obs, o_pump_down_obs, o_pump_oe, o_pump_high_impedance;
    logic        o_detector_polarity, o_buffer_on, o_cal_start_bit, o_cal_busy;
    logic [1:0]  o_out_ratio, o_backlash_width;
    logic [2:0]  o_pump_current_select;
    logic [6:0]  o_reference_mhz, o_reference_hundredths;
    logic [12:0] o_target_frequency_mhz, o_cal_target_mhz;
    logic [13:0] o_reference_divider_value, o_cal_ref_10khz;
    logic [31:0] m_su;   // model copy of the setup register
    logic [31:0] m_cal;  // model copy of the calibration register
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n_rf = 0;

    sscr_host_model host (.o_sclk(i_serial_clk), .o_sdata(i_serial_data), .o_strobe(i_serial_strobe));

    sscr_top #(.CAL_CYCLES(CAL_N)) uut (
        .i_clk_sys, .i_rst, .i_serial_clk, .i_serial_data, .i_serial_strobe, .i_buffer_enable_pin,
        .i_rf_in, .i_pfd_up, .i_pfd_down, .o_rf_out, .o_out_ratio, .o_pump_up_obs, .o_pump_down_obs,
        .o_pump_oe, .o_pump_high_impedance, .o_backlash_width, .o_detector_polarity,
        .o_reference_divider_value, .o_pump_current_select, .o_buffer_on, .o_reference_mhz,
        .o_reference_hundredths, .o_target_frequency_mhz, .o_cal_start_bit, .o_cal_busy,
        .o_cal_ref_10khz, .o_cal_target_mhz
    );

    // 40 MHz system clock
    always #12.5 i_clk_sys = ~i_clk_sys;

    // counts every change of the divided output
    always @(o_rf_out) n_rf++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // waits n rising edges and steps just past the last one
    task automatic clk_n(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : clk_n

    // compares every decoded field except the pulse test and start bits with the model registers
    task automatic check_all();
        check(o_out_ratio, m_su[9:8]);
        check(o_pump_high_impedance, m_su[29]);
        check(o_pump_oe, !m_su[29]);
        check(o_backlash_width, m_su[27:26]);
        check(o_detector_polarity, m_su[28]);
        check(o_reference_divider_value, m_su[25:12]);
        check(o_pump_current_select, m_su[7:5]);
        check(o_buffer_on, m_su[10] ? i_buffer_enable_pin : !m_su[11]);
        check(o_reference_mhz, m_cal[10:4]);
        check(o_reference_hundredths, m_cal[17:11]);
        check(o_target_frequency_mhz, m_cal[30:18]);
    endtask : check_all

    // sends one word, lets it settle, updates the model and compares
    task automatic put(input logic [31:0] w);
        host.send_word(w);
        clk_n(6);
        if (w[3:0] == 4'h0 && w[4]) begin
            m_su  = 32'h0000_1000;
            m_cal = 32'h0000_0000;
        end else if (w[3:0] == 4'h0) m_su = w;
        else if (w[3:0] == 4'h1) m_cal = w;
        check_all();
    endtask : put

    // cuts a hung run short
    initial begin
        #2ms;
        n_mismatch++;
        summarize();
    end

    // main sequence
    initial begin
        logic [31:0] w;
        int          n;
        int          n_start;
        w     = $urandom(32);
        m_su  = 32'h0000_1000; // reference divider defaults to one
        m_cal = 32'h0000_0000;
        repeat (4) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        clk_n(3);
        check_all();
        // random setup words, every third with an unmapped select
        for (int k = 0; k < 9; k++) begin
            w    = $urandom();
            w[4] = 1'b0;
            w[3:0] = (k % 3 == 2) ? 4'($urandom_range(15, 2)) : 4'h0;
            i_buffer_enable_pin = 1'($urandom());
            put(w);
        end
        // buffer state tracks the pin when the pin is selected
        put(32'h0000_0400);
        i_buffer_enable_pin = ~i_buffer_enable_pin;
        clk_n(4);
        check(o_buffer_on, i_buffer_enable_pin);
        // detector pulses reach the observation outputs only in test mode
        for (int t = 1; t >= 0; t--) begin
            put({1'b0, 1'(t), 30'h0}); // tristate bit kept clear for normal drive
            for (int k = 0; k < 16; k++) begin
                i_pfd_up   = 1'($urandom());
                i_pfd_down = 1'($urandom());
                clk_n(1);
                check(o_pump_up_obs, i_pfd_up & 1'(t));
                check(o_pump_down_obs, i_pfd_down & 1'(t));
            end
        end
        // 32 input rises through each divide ratio; code 11 acts as divide by one
        for (int r = 0; r < 4; r++) begin
            put({22'h0, 2'(r), 8'h0});
            n_rf = 0;
            repeat (64) begin
                i_rf_in = ~i_rf_in;
                clk_n(4);
            end
            clk_n(8);
            check(n_rf, (r == 3) ? 64 : (64 >> r));
        end
        // calibration run on a whole-MHz target
        w = {1'b1, 13'($urandom_range(8191)), 7'($urandom_range(99)), 7'($urandom_range(104, 10)), 4'h1};
        n       = 0;
        n_start = 0;
        fork
            put(w);
            repeat (330) begin
                clk_n(1);
                n       += (o_cal_busy === 1'b1);
                n_start += (o_cal_start_bit === 1'b1);
            end
        join
        check(n, CAL_N);
        check(n_start, CAL_N);
        check(o_cal_start_bit, 1'b0);
        check(o_cal_ref_10khz, int'(w[10:4]) * 100 + int'(w[17:11]));
        check(o_cal_target_mhz, w[30:18]);
        // a calibration word without the start bit loads its fields and launches nothing
        w = {1'b0, 13'($urandom_range(8191)), 7'($urandom_range(99)), 7'($urandom_range(104, 10)), 4'h1};
        put(w);
        check(o_cal_busy, 1'b0);
        check(o_cal_start_bit, 1'b0);
        // reset word with stray fields returns both registers to defaults
        put(32'h5FFF_FF10);
        summarize();
    end
endmodule : tb_top
